// *** scd_map.vh ***
// Register map and field positions of the stop-sequence collision block.
// Assumes a 32-bit Avalon-MM slave with word-aligned byte addresses.
`ifndef SCD_MAP_VH
`define SCD_MAP_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define SCD_OFF_BAUD     6'h00
`define SCD_OFF_BUF      6'h04
`define SCD_OFF_CTL1     6'h08
`define SCD_OFF_CTL2     6'h0C
`define SCD_OFF_CTL3     6'h10
`define SCD_OFF_MASK     6'h14
`define SCD_OFF_STAT     6'h18
`define SCD_OFF_IRQ_STAT 6'h1C
`define SCD_OFF_IRQ_MASK 6'h20

// ****************************************************************
// Field positions
// ****************************************************************
`define SCD_CTL1_WRITE_COLLISION_FLAG    7
`define SCD_CTL1_EN      5
`define SCD_CTL2_STOP    2
`define SCD_STAT_STOP    4
`define SCD_IRQ_PORT     0
`define SCD_IRQ_BCOL     1

// ****************************************************************
// Reset values
// ****************************************************************
`define SCD_RST_BYTE     8'h00
`define SCD_RST_BAUD     8'h09
`define SCD_RST_IRQ      2'h0

// ****************************************************************
// Timing
// ****************************************************************
`define SCD_SYNC_STAGES  2

`endif

// *** scd_sync.v ***
// Two-stage synchroniser for one level from outside the clock domain.
// Assumes the input may change at any time relative to core_clk.
`default_nettype none

module scd_sync
(
  // Clock and reset
  input  wire core_clk,
  input  wire sys_rst,
  // Level in and out
  input  wire async_in,
  output reg  sync_out
);

  reg meta;

  // Only the second stage is read; the first may be metastable.
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      meta     <= 1'b1;
      sync_out <= 1'b1;
    end
    else
    begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule

`default_nettype wire

// *** scd_baud.v ***
// Baud rate down-counter for the stop-sequence block.
// Assumes load and the reload value come from the same clock domain.
`include "scd_map.vh"
`default_nettype none

module scd_baud
#(
  parameter WIDTH = 8
)
(
  // Clock and reset
  input  wire             core_clk,
  input  wire             sys_rst,
  // Control
  input  wire             load,
  input  wire [WIDTH-1:0] reload,
  // Status
  output wire             expired
);

  reg [WIDTH-1:0] baud_rate_counter;
  reg             running;

  // Counts down to zero once per load, then stops.
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      baud_rate_counter <= {WIDTH{1'b0}};
      running           <= 1'b0;
    end
    else if (load)
    begin
      baud_rate_counter <= reload;
      running           <= 1'b1;
    end
    else if (running && baud_rate_counter != {WIDTH{1'b0}})
      baud_rate_counter <= baud_rate_counter - {{(WIDTH-1){1'b0}}, 1'b1};
    else
      running <= 1'b0;
  end

  assign expired = running && (baud_rate_counter == {WIDTH{1'b0}});

endmodule

`default_nettype wire

// *** scd_stop.v ***
// Master stop-sequence generator with bus collision detection.
// Assumes open-drain SDA/SCL pins resolved outside; pin inputs are
// asynchronous and pass two flip-flops before use.
//
// Behaviour
// - Stop starts by driving SDA low.
// - SDA read low, then release SCL.
// - Wait SCL high, then count baud period.
// - SDA low after expiry flags collision.
// - SCL low before SDA release flags collision.
// - Collision sets flag, port returns idle.
// - Collision aborts, releases lines, clears request.
// - Stop seen sets status; start, disable or reset clears.
// - Buffer write during stop sets write collision.
//
// The placing of the registers and register access over Avalon-MM are this design's own decisions.
`include "scd_map.vh"
`default_nettype none

module scd_stop
(
  // Clock and reset
  input  wire        core_clk,
  input  wire        sys_rst,
  // Avalon-MM slave
  input  wire [5:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  // Two-wire bus pins
  input  wire        sda_in,
  output wire        sda_out,
  output wire        sda_oe,
  input  wire        scl_in,
  output wire        scl_out,
  output wire        scl_oe,
  // Interrupt
  output wire        irq
);

  // ****************************************************************
  // State encoding
  // ****************************************************************
  localparam [5:0] ST_IDLE     = 6'h01;
  localparam [5:0] ST_SDA_LOW  = 6'h02;
  localparam [5:0] ST_SCL_WAIT = 6'h04;
  localparam [5:0] ST_SCL_HIGH = 6'h08;
  localparam [5:0] ST_SDA_REL  = 6'h10;
  localparam [5:0] ST_DONE     = 6'h20;

  // ****************************************************************
  // Registers and wires
  // ****************************************************************
  reg  [7:0] baud_reload_value;
  reg  [7:0] transfer_buffer;
  reg  [7:0] control_one;
  reg  [7:0] control_two;
  reg  [7:0] control_three;
  reg  [7:0] address_mask;
  reg        stop_detected;
  reg  [1:0] irq_status;
  reg  [1:0] irq_mask;
  reg  [5:0] state;
  reg        drive_sda_low;
  reg        drive_scl_low;
  reg        ack_cycle;
  reg        baud_load;
  wire       sda_s;
  wire       scl_s;
  wire       baud_expired;
  wire       port_enabled;
  wire       stop_sequence_request;
  wire       stop_busy;
  wire       collision_sda;
  wire       collision_scl;
  wire       collision;
  wire       stop_finish;
  wire       bus_write;
  wire       bus_read;
  wire [7:0] wbyte;

  assign port_enabled          = control_one[`SCD_CTL1_EN];
  assign stop_sequence_request = control_two[`SCD_CTL2_STOP];
  assign stop_busy             = (state != ST_IDLE);
  assign wbyte                 = avs_writedata[7:0];

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  scd_sync u_sda_sync
  (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .async_in (sda_in),
    .sync_out (sda_s)
  );

  scd_sync u_scl_sync
  (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .async_in (scl_in),
    .sync_out (scl_s)
  );

  // ****************************************************************
  // Baud period timer
  // ****************************************************************
  scd_baud #(.WIDTH(8)) u_baud
  (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .load     (baud_load),
    .reload   (baud_reload_value),
    .expired  (baud_expired)
  );

  // Open-drain pins: only ever pull low, enable is the drive.
  // Driving a one would fight other masters, so the data pins stay at zero.
  assign sda_out = 1'b0;
  assign scl_out = 1'b0;
  assign sda_oe  = drive_sda_low;
  assign scl_oe  = drive_scl_low;

  // Collision cases: SDA low after the period, or SCL pulled low early.
  // A master still driving a zero shows up as SDA low when the period ends.
  assign collision_sda = (state == ST_SDA_REL) && baud_expired && !sda_s;
  // SCL only counts until SDA is seen high; after that the stop is on the
  // wire and a falling SCL belongs to whoever starts the next transfer.
  assign collision_scl = ((state == ST_SCL_HIGH) || (state == ST_SDA_REL)) && !scl_s
                         && !((state == ST_SDA_REL) && sda_s);
  assign collision     = collision_sda || collision_scl;
  assign stop_finish = (state == ST_DONE) && baud_expired;

  // ****************************************************************
  // Stop sequence state machine
  // ****************************************************************
  // Disabling the port drops the sequence so stale drives never stick.
  always @(posedge core_clk)
  begin
    if (sys_rst || !port_enabled)
    begin
      state         <= ST_IDLE;
      drive_sda_low <= 1'b0;
      drive_scl_low <= 1'b0;
      baud_load     <= 1'b0;
    end
    else
    begin
      // The load strobe is a one-cycle pulse unless a state asks again.
      baud_load <= 1'b0;
      if (collision)
      begin
        state         <= ST_IDLE;
        drive_sda_low <= 1'b0;
        drive_scl_low <= 1'b0;
      end
      else
      begin
        case (state)
          ST_IDLE:
            if (stop_sequence_request)
            begin
              drive_sda_low <= 1'b1;
              drive_scl_low <= 1'b1;
              state         <= ST_SDA_LOW;
            end
          ST_SDA_LOW:
            if (!sda_s)
            begin
              drive_scl_low <= 1'b0;
              state         <= ST_SCL_WAIT;
            end
          ST_SCL_WAIT:
            if (scl_s)
            begin
              baud_load <= 1'b1;
              state     <= ST_SCL_HIGH;
            end
          ST_SCL_HIGH:
            if (baud_expired)
            begin
              drive_sda_low <= 1'b0;
              baud_load     <= 1'b1;
              state         <= ST_SDA_REL;
            end
          ST_SDA_REL:
            if (baud_expired)
            begin
              baud_load <= 1'b1;
              state     <= ST_DONE;
            end
          ST_DONE:
            if (baud_expired)
              state <= ST_IDLE;
          default:
            state <= ST_IDLE;
        endcase
      end
    end
  end

  // ****************************************************************
  // Stop-detected status bit
  // ****************************************************************
  // Set on SDA rising while SCL high; cleared by SDA falling while SCL high, by disable or by reset.
  // The edge detector idles high like the pin, so reset shows no false edge.
  reg sda_d;
  always @(posedge core_clk)
  begin
    if (sys_rst || !port_enabled)
    begin
      stop_detected <= 1'b0;
      sda_d         <= 1'b1;
    end
    else
    begin
      sda_d <= sda_s;
      if (sda_s && !sda_d && scl_s)
        stop_detected <= 1'b1;
      else if (!sda_s && sda_d && scl_s)
        stop_detected <= 1'b0;
    end
  end

  // ****************************************************************
  // Avalon-MM slave
  // ****************************************************************
  // One wait cycle on every access keeps read data registered.
  // The master holds its request through that cycle, so both edges see it.
  assign avs_waitrequest = (avs_read || avs_write) && !ack_cycle;
  assign bus_write       = avs_write && ack_cycle;
  assign bus_read        = avs_read && ack_cycle;

  always @(posedge core_clk)
  begin
    if (sys_rst)
      ack_cycle <= 1'b0;
    else
      ack_cycle <= (avs_read || avs_write) && !ack_cycle;
  end

  // Register writes; hardware clears of the stop request win over software writes.
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      baud_reload_value <= `SCD_RST_BAUD;
      transfer_buffer   <= `SCD_RST_BYTE;
      control_one       <= `SCD_RST_BYTE;
      control_two       <= `SCD_RST_BYTE;
      control_three     <= `SCD_RST_BYTE;
      address_mask      <= `SCD_RST_BYTE;
      irq_mask          <= `SCD_RST_IRQ;
    end
    else
    begin
      if (bus_write && avs_byteenable[0])
      begin
        if (avs_address == `SCD_OFF_BAUD)
          baud_reload_value <= wbyte;
        else if (avs_address == `SCD_OFF_BUF)
        begin
          if (stop_busy)
            control_one[`SCD_CTL1_WRITE_COLLISION_FLAG] <= 1'b1;
          else
            transfer_buffer <= wbyte;
        end
        else if (avs_address == `SCD_OFF_CTL1)
          control_one <= {control_one[`SCD_CTL1_WRITE_COLLISION_FLAG] & wbyte[7], wbyte[6:0]};
        else if (avs_address == `SCD_OFF_CTL2)
          control_two <= wbyte;
        else if (avs_address == `SCD_OFF_CTL3)
          control_three <= wbyte;
        else if (avs_address == `SCD_OFF_MASK)
          address_mask <= wbyte;
        else if (avs_address == `SCD_OFF_IRQ_MASK)
          irq_mask <= wbyte[1:0];
      end
      // Abort or completion drops the request after any software write.
      if (collision || stop_finish)
        control_two[`SCD_CTL2_STOP] <= 1'b0;
      if (!port_enabled)
        control_two[`SCD_CTL2_STOP] <= 1'b0;
    end
  end

  // Sticky event bits, cleared by a read; a new event wins the clear.
  always @(posedge core_clk)
  begin
    if (sys_rst)
      irq_status <= `SCD_RST_IRQ;
    else
    begin
      // Only the bits the read reported are cleared, so an event landing
      // between the capture of read data and the clear is not lost.
      if (bus_read && avs_address == `SCD_OFF_IRQ_STAT)
        irq_status <= irq_status & ~avs_readdata[1:0];
      if (stop_finish)
        irq_status[`SCD_IRQ_PORT] <= 1'b1;
      if (collision)
        irq_status[`SCD_IRQ_BCOL] <= 1'b1;
    end
  end

  assign irq = |(irq_status & irq_mask);

  // Registered read data; unmapped addresses read as zero.
  // Captured in the wait cycle, so it stands at the edge where waitrequest drops.
  always @(posedge core_clk)
  begin
    if (sys_rst)
      avs_readdata <= 32'h00000000;
    else if (avs_read && !ack_cycle)
    begin
      if (avs_address == `SCD_OFF_BAUD)
        avs_readdata <= {24'h000000, baud_reload_value};
      else if (avs_address == `SCD_OFF_BUF)
        avs_readdata <= {24'h000000, transfer_buffer};
      else if (avs_address == `SCD_OFF_CTL1)
        avs_readdata <= {24'h000000, control_one};
      else if (avs_address == `SCD_OFF_CTL2)
        avs_readdata <= {24'h000000, control_two};
      else if (avs_address == `SCD_OFF_CTL3)
        avs_readdata <= {24'h000000, control_three};
      else if (avs_address == `SCD_OFF_MASK)
        avs_readdata <= {24'h000000, address_mask};
      else if (avs_address == `SCD_OFF_STAT)
        avs_readdata <= {27'h0000000, stop_detected, 4'h0};
      else if (avs_address == `SCD_OFF_IRQ_STAT)
        avs_readdata <= {30'h00000000, irq_status};
      else if (avs_address == `SCD_OFF_IRQ_MASK)
        avs_readdata <= {30'h00000000, irq_mask};
      else
        avs_readdata <= 32'h00000000;
    end
  end

endmodule

`default_nettype wire

// *** scd_stop_props.sv ***
// Concurrent checks on the ports of the stop-sequence block.
// Assumes it is bound to the top module and sees nothing inside it.
`default_nettype none
module scd_stop_props
(
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        sys_rst,
  // Register bus
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Pins and interrupt
  input wire logic        sda_in,
  input wire logic        sda_oe,
  input wire logic        scl_in,
  input wire logic        scl_oe,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] baud;
  logic       en;
  logic [1:0] msk;
  logic [7:0] hi_cnt;
  wire        wr_done = avs_write && !avs_waitrequest && avs_byteenable[0];
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Shadow the fields the checks lean on, so expectations follow software writes.
  always @(posedge core_clk)
    if (sys_rst)
    begin
      baud <= 8'h09;
      en   <= 1'b0;
      msk  <= 2'h0;
    end
    else if (wr_done)
      case (avs_address)
        6'h00: baud <= avs_writedata[7:0];
        6'h08: en <= avs_writedata[5];
        6'h20: msk <= avs_writedata[1:0];
        default: ;
      endcase
  // Count how long SCL has read high; saturates so it never wraps to a small value.
  always @(posedge core_clk)
    if (sys_rst || !scl_in)
      hi_cnt <= 8'h00;
    else if (hi_cnt != 8'hFF)
      hi_cnt <= hi_cnt + 8'h01;
  wait_one_a: assert property ($rose(avs_read || avs_write) |->
    avs_waitrequest ##1 !avs_waitrequest) else $error("bus wait not one cycle");
  rst_quiet_a: assert property ($fell(sys_rst) |-> !sda_oe && !scl_oe && !irq)
    else $error("pins or irq active after reset");
  stop_start_a: assert property (
    wr_done && avs_address == 6'h0C && avs_writedata[2] && en && !sda_oe |->
    ##[1:2] sda_oe && scl_oe) else $error("stop did not start by pulling SDA");
  scl_after_sda_a: assert property ($fell(scl_oe) && sda_oe |-> !$past(sda_in, 2))
    else $error("SCL released before SDA read low");
  scl_release_a: assert property ($rose(sda_oe) |-> ##[1:6] !scl_oe)
    else $error("SCL not released after SDA low");
  sda_hold_a: assert property ($fell(sda_oe) && scl_in |-> hi_cnt >= baud + 8'h01)
    else $error("SDA released before SCL high for one baud period");
  scl_low_abort_a: assert property (
    sda_oe && !scl_oe && $fell(scl_in) |-> ##[1:5] !sda_oe && !scl_oe)
    else $error("SCL low during stop not treated as collision");
  irq_mask_a: assert property (msk == 2'h0 |-> !irq)
    else $error("interrupt raised while masked");
  read_upper_a: assert property (avs_read && !avs_waitrequest |->
    avs_readdata[31:8] == 24'h0 && (avs_address <= 6'h20 || avs_readdata == 32'h0))
    else $error("read data outside the byte lane");
endmodule
bind scd_stop scd_stop_props i_props (.core_clk(core_clk), .sys_rst(sys_rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sda_in(sda_in),
  .sda_oe(sda_oe), .scl_in(scl_in), .scl_oe(scl_oe), .irq(irq));
`default_nettype wire

// *** scd_bus_model.sv ***
// Far side of the two-wire bus: pull-ups, a stretching slave, a rival master.
// Assumes the device's enables mean pull low and the bench picks the behaviour.
`default_nettype none
module scd_bus_model
(
  // Device side
  input  wire logic sda_oe,
  input  wire logic scl_oe,
  // Behaviour chosen by the bench
  input  wire logic hold_scl,
  input  wire logic hold_sda,
  input  wire logic rival_en,
  // Resolved wires
  output wire logic sda_in,
  output wire logic scl_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rival_clk = 1'b1;
  // The rival's 80 ns clock runs only while it competes, else it rests high.
  always
  begin
    #40;
    rival_clk = rival_en ? !rival_clk : 1'b1;
  end
  // Open-drain wires with pull-ups: any party pulling low wins.
  assign sda_in = !(sda_oe || hold_sda);
  assign scl_in = !(scl_oe || hold_scl || !rival_clk);
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Testbench of the stop-sequence block, driven over Avalon-MM.
// Assumes the bus model on the pins and the bound checker.
`include "scd_map.vh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic        hold_scl = 1'b0;
  logic        hold_sda = 1'b0;
  logic        rival_en = 1'b0;
  logic [31:0] q;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest, sda_in, sda_oe, scl_in, scl_oe, irq, sda_out, scl_out;
  int          n_fail = 0;
  int          tests_run = 0;
  // Free-running 100 MHz clock.
  always #5 core_clk = !core_clk;
  scd_stop i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .scl_in(scl_in), .scl_out(scl_out),
    .scl_oe(scl_oe), .irq(irq));
  scd_bus_model i_bus (.sda_oe(sda_oe), .scl_oe(scl_oe), .hold_scl(hold_scl),
    .hold_sda(hold_sda), .rival_en(rival_en), .sda_in(sda_in), .scl_in(scl_in));
  // One bus access; the request stands until waitrequest is sampled low.
  task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d);
    begin
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= {24'h000000, d};
      avs_write <= w;
      avs_read <= !w;
      @(posedge core_clk);
      while (avs_waitrequest !== 1'b0)
        @(posedge core_clk);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
    end
  endtask
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    begin
      tests_run++;
      if (g !== e)
      begin
        n_fail++;
        $display("ERROR at %0t: expected %h got %h", $time, e, g);
      end
    end
  endtask
  // Read and compare the bits selected by m.
  task automatic rc(input logic [5:0] a, input logic [7:0] m, input logic [7:0] e);
    begin
      acc(1'b0, a, 8'h00);
      chk({24'h0, e & m}, q & {24'h0, m});
    end
  endtask
  // Start a stop and wait until the device has taken SDA.
  task automatic go;
    begin
      acc(1'b1, `SCD_OFF_CTL2, 8'h04);
      while (sda_oe !== 1'b1)
        @(posedge core_clk);
    end
  endtask
  task automatic results;
    begin
      $display("Checks %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  // Watchdog: the tests need well under 2000 cycles.
  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    results();
  end
  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial
  begin
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    rc(`SCD_OFF_BAUD, 8'hFF, `SCD_RST_BAUD);
    rc(`SCD_OFF_CTL1, 8'hFF, 8'h00);
    rc(6'h24, 8'hFF, 8'h00);
    acc(1'b1, `SCD_OFF_BAUD, 8'h07);
    rc(`SCD_OFF_BAUD, 8'hFF, 8'h07);
    acc(1'b1, `SCD_OFF_CTL1, 8'h20);
    $display("test reset done");
    // A slave stretches SCL; a buffer write meanwhile must be dropped.
    hold_scl <= 1'b1;
    go();
    repeat (20) @(negedge core_clk);
    chk(32'h2, {30'h0, sda_oe, scl_oe});
    chk(32'h0, {30'h0, sda_out, scl_out});
    acc(1'b1, `SCD_OFF_BUF, 8'h5A);
    rc(`SCD_OFF_CTL1, 8'hFF, 8'hA0);
    rc(`SCD_OFF_BUF, 8'hFF, 8'h00);
    acc(1'b1, `SCD_OFF_CTL1, 8'h20);
    hold_scl <= 1'b0;
    q = 32'h4;
    while (q[2])
      acc(1'b0, `SCD_OFF_CTL2, 8'h00);
    @(negedge core_clk);
    chk(32'h0, {31'h0, irq});
    acc(1'b1, `SCD_OFF_IRQ_MASK, 8'h03);
    @(negedge core_clk);
    chk(32'h1, {31'h0, irq});
    rc(`SCD_OFF_IRQ_STAT, 8'hFF, 8'h01);
    rc(`SCD_OFF_STAT, 8'h10, 8'h10);
    rc(`SCD_OFF_IRQ_STAT, 8'hFF, 8'h00);
    $display("test normal stop done");
    // Another master holds SDA low once it has been released.
    go();
    while (sda_oe !== 1'b0)
      @(posedge core_clk);
    hold_sda <= 1'b1;
    repeat (30) @(negedge core_clk);
    chk(32'h4, {29'h0, irq, sda_oe, scl_oe});
    rc(`SCD_OFF_IRQ_STAT, 8'h02, 8'h02);
    rc(`SCD_OFF_CTL2, 8'h04, 8'h00);
    hold_sda <= 1'b0;
    $display("test sda collision done");
    // A rival clock pulls SCL low before SDA is released.
    go();
    while (scl_oe !== 1'b0)
      @(posedge core_clk);
    repeat (2) @(posedge core_clk);
    rival_en <= 1'b1;
    repeat (30) @(negedge core_clk);
    chk(32'h4, {29'h0, irq, sda_oe, scl_oe});
    rival_en <= 1'b0;
    rc(`SCD_OFF_IRQ_STAT, 8'h02, 8'h02);
    rc(`SCD_OFF_CTL2, 8'h04, 8'h00);
    $display("test scl collision done");
    // With the port disabled a stop request is ignored.
    acc(1'b1, `SCD_OFF_CTL1, 8'h00);
    acc(1'b1, `SCD_OFF_CTL2, 8'h04);
    repeat (4) @(negedge core_clk);
    chk(32'h0, {30'h0, sda_oe, scl_oe});
    rc(`SCD_OFF_CTL2, 8'h04, 8'h00);
    $display("test disabled done");
    results();
  end
endmodule
`default_nettype wire
